// ===== bench/sdram_cal_monitor.sv
// Purpose: Port timing checks for the SDRAM core
// Assumes: Controller keeps bank and mode-load rules
// Notes:   Mirrors mode and open banks from the pins
`timescale 1ns/10ps
module sdram_cal_monitor
  import sdram_pkg::*;
(
  // Clock and reset
  input wire logic              i_clk_sys,
  input wire logic              i_rst,
  // Command pins
  input wire logic              i_cke,
  input wire logic              i_cs_n,
  input wire logic              i_ras_n,
  input wire logic              i_cas_n,
  input wire logic              i_we_n,
  input wire logic              i_bank_sel_low,
  input wire logic              i_bank_sel_high,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [LANES-1:0]  i_dqm,
  // Outputs watched
  input wire logic [LANES-1:0]  o_dq_oe,
  input wire logic              o_self_refresh
);
  logic [ADDR_W-1:0] mode_reg;
  logic [BANKS-1:0]  open_reg;
  logic [3:0]        since_reg;
  logic              cke_reg;
  logic [2:0]        pat, cl;
  logic [1:0]        bank;
  logic              take, rd, rd_ok, idle;
  // Decode as the core does, clock enable one edge late
  assign pat   = {i_ras_n, i_cas_n, i_we_n};
  assign cl    = mode_reg[CL_LSB+:CL_W];
  assign bank  = {i_bank_sel_high, i_bank_sel_low};
  assign take  = cke_reg && !i_cs_n;
  assign rd    = take && pat == PIN_READ;
  assign rd_ok = rd && open_reg[bank] && mode_reg[8:7] == OPM_NORMAL &&
                 cl inside {CL_ONE, CL_TWO, CL_THREE};
  assign idle  = i_cke && (i_cs_n || pat == PIN_NOP);
  // Auto close counts as closed at once, so rd_ok stays conservative
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cke_reg   <= 1'b0;
      mode_reg  <= MODE_RESET;
      open_reg  <= '0;
      since_reg <= 4'hf;
    end
    else
    begin
      cke_reg   <= i_cke;
      since_reg <= rd ? 4'h0 : since_reg + {3'h0, since_reg != 4'hf};
      if (take && pat == PIN_LOAD)
        mode_reg <= i_addr;
      if (take && pat == PIN_ACTIVE)
        open_reg[bank] <= 1'b1;
      if (take && pat == PIN_CLOSE)
        open_reg <= i_addr[10] ? '0 : open_reg & ~(4'h1 << bank);
      if ((rd || (take && pat == PIN_WRITE)) && i_addr[10])
        open_reg[bank] <= 1'b0;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_cl1; (i_dqm == 4'h0) ##1 (rd_ok && cl == CL_ONE)
    |=> o_dq_oe == 4'hf; endproperty
  a_cl1: assert property (p_cl1) else $error("latency one late");
  property p_cl2; (rd_ok && i_cke && cl == CL_TWO) ##1 idle
    |=> o_dq_oe == ~$past(i_dqm, 2); endproperty
  a_cl2: assert property (p_cl2) else $error("latency two lanes");
  property p_cl3; (rd_ok && i_cke && cl == CL_THREE) ##1
    (idle && i_dqm == 4'h0) ##1 idle |=> o_dq_oe == 4'hf; endproperty
  a_cl3: assert property (p_cl3) else $error("latency three late");
  property p_quiet; since_reg > 4'h3 && mode_reg[2:0] == BL_ONE
    |-> o_dq_oe == 4'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("drive w/o read");
  property p_opm; rd && mode_reg[8:7] != OPM_NORMAL && since_reg > 4'h3
    |=> (o_dq_oe == 4'h0) [*3]; endproperty
  a_opm: assert property (p_opm) else $error("test mode read");
  property p_self; take && pat == PIN_REFRESH
    |=> o_self_refresh == !$past(i_cke); endproperty
  a_self: assert property (p_self) else $error("refresh kind");
  property p_hold; o_self_refresh && !$past(i_cke)
    |=> o_self_refresh; endproperty
  a_hold: assert property (p_hold) else $error("self refresh left");
  property p_load; take && pat == PIN_LOAD |=> o_dq_oe == 4'h0;
  endproperty
  a_load: assert property (p_load) else $error("drive after load");
  // Main scenarios reached
  c_read: cover property (rd_ok);
  c_load: cover property (take && pat == PIN_LOAD);
  c_self: cover property ($rose(o_self_refresh));
  c_stop: cover property (take && pat == PIN_STOP);
endmodule

// ===== bench/sdram_ctrl_model.sv
// Purpose: Memory controller model driving the SDRAM pins
// Assumes: Shares the device clock, changes pins on falling edges
// Notes:   A released data bus shows the inverse of its last value
`timescale 1ns/10ps
module sdram_ctrl_model
  import sdram_pkg::*;
(
  // Clock
  input  wire logic         i_clk_sys,
  // Pins toward the device
  output logic              o_cke,
  output logic              o_cs_n,
  output logic [2:0]        o_pat,
  output logic [BANK_W-1:0] o_bank,
  output logic [ADDR_W-1:0] o_addr,
  output logic [LANES-1:0]  o_dqm,
  output logic [DQ_W-1:0]   o_dq
);
  // Deselected, clock enabled, from time zero
  initial
  begin
    o_cke  = 1'b1;
    o_cs_n = 1'b1;
    o_pat  = PIN_NOP;
    o_bank = '0;
    o_addr = '0;
    o_dqm  = '0;
    o_dq   = '0;
  end
  // One command a clock; zero data outside a write means the bus is released
  task automatic cmd(input logic s, input logic [2:0] p,
    input logic [1:0] b, input logic [11:0] a, input logic [3:0] m,
    input logic [31:0] d);
    @(negedge i_clk_sys);
    o_cs_n = s;
    o_pat  = p;
    o_bank = b;
    o_addr = a;
    o_dqm  = m;
    o_dq   = (p == PIN_WRITE || d != '0) ? d : ~o_dq;
  endtask
  // Low only alongside a self refresh entry
  task automatic set_cke(input logic v);
    o_cke = v;
  endtask
endmodule

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the SDRAM command and latency core
// Assumes: 20 MHz clock; pins change on falling edges
// Notes:   Bank 0 row 5 is the working row of every scenario
`timescale 1ns/10ps
module tb_top
  import sdram_pkg::*;
;
  localparam int MODE_LOAD_WAIT = 2;
  localparam int LIMIT          = 3000;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cke, cs_n, self_ref;
  logic [2:0]        pat;
  logic [1:0]        bank;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  dqm, dq_oe;
  logic [DQ_W-1:0]   dq_ctl, dq_in, dq_out;
  int                error_cnt = 0;
  int                checked = 0;
  int                cycles = 0;
  int                lat = 2;
  function automatic logic [31:0] lanes(input logic [3:0] e);
    return {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
  endfunction
  // Slow clock, fine for every latency
  always #25 clk = ~clk;
  // Data wire: device lanes win while enabled
  assign dq_in = (dq_out & lanes(dq_oe)) | (dq_ctl & ~lanes(dq_oe));
  sdram_ctrl_model ctrl (
    .i_clk_sys (clk),
    .o_cke     (cke),
    .o_cs_n    (cs_n),
    .o_pat     (pat),
    .o_bank    (bank),
    .o_addr    (addr),
    .o_dqm     (dqm),
    .o_dq      (dq_ctl)
  );
  sdram_command_and_latency dut (
    .i_clk_sys       (clk),
    .i_rst           (rst),
    .i_cke           (cke),
    .i_cs_n          (cs_n),
    .i_ras_n         (pat[2]),
    .i_cas_n         (pat[1]),
    .i_we_n          (pat[0]),
    .i_bank_sel_low  (bank[0]),
    .i_bank_sel_high (bank[1]),
    .i_addr          (addr),
    .i_dqm           (dqm),
    .i_dq_in         (dq_in),
    .o_dq_out        (dq_out),
    .o_dq_oe         (dq_oe),
    .o_self_refresh  (self_ref)
  );
  task automatic complete_run();
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the 150 or so cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic op(input logic [2:0] p, input logic [11:0] a,
    input logic [31:0] d = '0, input logic [3:0] m = '0,
    input logic [1:0] b = '0);
    ctrl.cmd(1'b0, p, b, a, m, d);
  endtask
  task automatic nop(input int n);
    repeat (n) op(PIN_NOP, 12'h000);
  endtask
  // Banks idle before a load, then the load wait
  task automatic prep(input logic [11:0] mode);
    op(PIN_CLOSE, 12'h400);
    op(PIN_LOAD, mode);
    nop(MODE_LOAD_WAIT);
    op(PIN_ACTIVE, 12'h005);
  endtask
  // One word read; lanes must switch on and off on time
  task automatic rd_chk(input logic [7:0] col, input logic [3:0] m,
    input logic [31:0] exp);
    logic [3:0] en;
    en = ~m;
    op(PIN_READ, {4'h0, col}, '0, m);
    nop(lat - 1);
    chk("oe early", dq_oe, 4'h0);
    nop(1);
    chk("oe", dq_oe, en);
    chk("data", dq_out & lanes(en), exp & lanes(en));
    nop(1);
    chk("oe late", dq_oe, 4'h0);
  endtask
  task automatic quiet();
    for (int i = 0; i < 4; i++)
    begin
      nop(1);
      chk("oe quiet", dq_oe, 4'h0);
    end
  endtask
  task automatic s_latency();
    for (int i = 1; i <= 3; i++)
    begin
      lat = i;
      prep({5'h0, 3'(i), 4'h0});
      op(PIN_WRITE, 12'h003, 32'h5a00_0000 + i);
      rd_chk(8'h03, 4'h0, 32'h5a00_0000 + i);
    end
  endtask
  // Write mask acts at once, read mask two clocks on
  task automatic s_mask();
    lat = 2;
    prep(12'h020);
    op(PIN_WRITE, 12'h001, 32'h1122_3344);
    op(PIN_WRITE, 12'h001, 32'haabb_ccdd, 4'h2);
    rd_chk(8'h01, 4'h8, 32'haabb_33dd);
  endtask
  // Two-word bursts, then single writes under the same count
  task automatic s_burst();
    prep(12'h021);
    op(PIN_WRITE, 12'h004, 32'h0000_00a4);
    op(PIN_NOP, 12'h000, 32'h0000_00a5);
    prep(12'h221);
    op(PIN_WRITE, 12'h004, 32'h0000_00c4);
    op(PIN_NOP, 12'h000, 32'h0000_00c5);
    prep(12'h020);
    rd_chk(8'h04, 4'h0, 32'h0000_00c4);
    rd_chk(8'h05, 4'h0, 32'h0000_00a5);
  endtask
  // Interleaved burst cut by stop; col 10 must keep its old word
  task automatic s_stop();
    op(PIN_WRITE, 12'h00a, 32'h0000_0e0a);
    prep(12'h02a);
    op(PIN_WRITE, 12'h009, 32'h0000_0b09);
    op(PIN_NOP, 12'h000, 32'h0000_0b08);
    op(PIN_STOP, 12'h000, 32'h0000_0b0b);
    op(PIN_NOP, 12'h000, 32'h0000_0b0a);
    prep(12'h020);
    rd_chk(8'h08, 4'h0, 32'h0000_0b08);
    rd_chk(8'h0a, 4'h0, 32'h0000_0e0a);
    // Single write with auto close leaves the bank idle at once
    op(PIN_WRITE, 12'h40a, 32'h0000_0f0a);
    op(PIN_READ, 12'h00a);
    quiet();
  endtask
  // Reads the core must drop
  task automatic s_refuse();
    ctrl.cmd(1'b1, PIN_READ, 2'h0, 12'h003, 4'h0, '0);
    quiet();
    op(PIN_READ, 12'h003, '0, 4'h0, 2'h1);
    quiet();
    op(PIN_CLOSE, 12'h000);
    op(PIN_READ, 12'h003);
    quiet();
    prep(12'h0a0);
    op(PIN_READ, 12'h003);
    quiet();
    prep(12'h040);
    op(PIN_READ, 12'h003);
    quiet();
  endtask
  task automatic s_refresh();
    op(PIN_CLOSE, 12'h400);
    op(PIN_REFRESH, 12'h000);
    nop(2);
    chk("auto ref", self_ref, 1'b0);
    op(PIN_REFRESH, 12'h000);
    ctrl.set_cke(1'b0);
    nop(3);
    chk("self ref", self_ref, 1'b1);
    ctrl.set_cke(1'b1);
    nop(3);
    chk("wake", self_ref, 1'b0);
  endtask
  // Reset for four clocks, then each scenario in turn
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    nop(2);
    s_latency();
    s_mask();
    s_burst();
    s_stop();
    s_refuse();
    s_refresh();
    complete_run();
  end
endmodule
bind sdram_command_and_latency sdram_cal_monitor mon (
  .i_clk_sys       (i_clk_sys),
  .i_rst           (i_rst),
  .i_cke           (i_cke),
  .i_cs_n          (i_cs_n),
  .i_ras_n         (i_ras_n),
  .i_cas_n         (i_cas_n),
  .i_we_n          (i_we_n),
  .i_bank_sel_low  (i_bank_sel_low),
  .i_bank_sel_high (i_bank_sel_high),
  .i_addr          (i_addr),
  .i_dqm           (i_dqm),
  .o_dq_oe         (o_dq_oe),
  .o_self_refresh  (o_self_refresh)
);

// ===== rtl/sdram_cmd_decode.sv
// Purpose: Turn command pins into one decoded command per clock
// Assumes: Pins come from logic on i_clk_sys, so no synchroniser
// Notes:   Clock enable acts one edge late, as on the real pins
`timescale 1ns/10ps
module sdram_cmd_decode
  import sdram_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Command pins
  input  wire logic              i_cke,
  input  wire logic              i_cs_n,
  input  wire logic              i_ras_n,
  input  wire logic              i_cas_n,
  input  wire logic              i_we_n,
  input  wire logic              i_bank_sel_low,
  input  wire logic              i_bank_sel_high,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [LANES-1:0]  i_dqm,
  // Decoded command
  sdram_cmd_if.src               cmd_out
);
  logic cke_prev_reg;
  logic cke_prev_next;

  // Clock enable seen on the previous edge
  always_comb
  begin
    cke_prev_next = i_cke;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      cke_prev_reg <= 1'b0;
    else
      cke_prev_reg <= cke_prev_next;
  end

  // Pin decode; deselect beats every strobe pattern
  always_comb
  begin
    cmd_out.active = cke_prev_reg;
    cmd_out.bank   = {i_bank_sel_high, i_bank_sel_low};
    cmd_out.addr   = i_addr;
    cmd_out.mask   = i_dqm;
    cmd_out.cmd    = CMD_NONE;
    if (!i_cs_n)
    begin
      case ({i_ras_n, i_cas_n, i_we_n})
        PIN_NOP:     cmd_out.cmd = CMD_NONE;
        PIN_ACTIVE:  cmd_out.cmd = CMD_ACTIVE;
        PIN_READ:    cmd_out.cmd = CMD_READ;
        PIN_WRITE:   cmd_out.cmd = CMD_WRITE;
        PIN_STOP:    cmd_out.cmd = CMD_STOP;
        PIN_CLOSE:   cmd_out.cmd = CMD_CLOSE;
        PIN_REFRESH: cmd_out.cmd = i_cke ? CMD_AUTO_REF : CMD_SELF_REF;
        default:     cmd_out.cmd = CMD_LOAD;
      endcase
    end
  end
endmodule

// ===== rtl/sdram_cmd_if.sv
// Purpose: Decoded command from the pin decoder to the device core
// Assumes: Same clock on both ends
// Notes:   Fields are combinational, valid when active is high
`timescale 1ns/10ps
interface sdram_cmd_if import sdram_pkg::*; ();
  logic              active;
  cmd_type           cmd;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  mask;
  modport src  (output active, cmd, bank, addr, mask);
  modport sink (input  active, cmd, bank, addr, mask);
endinterface

// ===== rtl/sdram_command_and_latency.sv
// Purpose: Four-bank SDRAM device core: commands, bursts, read latency
// Assumes: Controller runs on i_clk_sys and keeps its own timing waits
// Notes:   Array is a small flop model indexed by bank, row and column
`timescale 1ns/10ps

module sdram_command_and_latency
  import sdram_pkg::*;
#(
  parameter int ROW_IDX_W = 2,
  parameter int COL_IDX_W = 4
)
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Command pins
  input  wire logic              i_cke,
  input  wire logic              i_cs_n,
  input  wire logic              i_ras_n,
  input  wire logic              i_cas_n,
  input  wire logic              i_we_n,
  input  wire logic              i_bank_sel_low,
  input  wire logic              i_bank_sel_high,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [LANES-1:0]  i_dqm,
  // Data pins
  input  wire logic [DQ_W-1:0]   i_dq_in,
  output logic      [DQ_W-1:0]   o_dq_out,
  output logic      [LANES-1:0]  o_dq_oe,
  // Status
  output logic                   o_self_refresh
);
  localparam int IDX_W = BANK_W + ROW_IDX_W + COL_IDX_W;
  localparam int DEPTH = 1 << IDX_W;

  sdram_cmd_if cmd_bus ();

  // Burst engine state
  burst_type          state_reg, state_next;
  logic [BANK_W-1:0]  bank_reg, bank_next;
  logic [COL_W-1:0]   start_reg, start_next;
  logic [8:0]         cnt_reg, cnt_next;
  logic [8:0]         len_reg, len_next;
  logic               close_reg, close_next;
  // Bank, mode and refresh state
  logic [BANKS-1:0]   open_reg, open_next;
  logic [ROW_IDX_W-1:0] row_reg [BANKS];
  logic [ROW_IDX_W-1:0] row_next [BANKS];
  logic [ADDR_W-1:0]  mode_reg, mode_next;
  logic               self_ref_next;
  // Array
  logic [DQ_W-1:0]    mem_reg [DEPTH];
  logic [DQ_W-1:0]    mem_next [DEPTH];
  // Word access of this edge
  logic               acc_valid;
  logic               acc_write;
  logic [BANK_W-1:0]  acc_bank;
  logic [COL_W-1:0]   acc_col;
  logic [IDX_W-1:0]   acc_idx;
  logic               flush;
  logic [8:0]         new_len;
  logic               normal_mode;
  logic               cl_ok;
  logic [CL_W-1:0]    cl_code;

  sdram_cmd_decode u_decode (
    .i_clk_sys       (i_clk_sys),
    .i_rst           (i_rst),
    .i_cke           (i_cke),
    .i_cs_n          (i_cs_n),
    .i_ras_n         (i_ras_n),
    .i_cas_n         (i_cas_n),
    .i_we_n          (i_we_n),
    .i_bank_sel_low  (i_bank_sel_low),
    .i_bank_sel_high (i_bank_sel_high),
    .i_addr          (i_addr),
    .i_dqm           (i_dqm),
    .cmd_out         (cmd_bus)
  );

  // Mode decode
  always_comb
  begin
    cl_code     = mode_reg[CL_LSB +: CL_W];
    normal_mode = (mode_reg[OPM_LSB +: OPM_W] == OPM_NORMAL);
    // Reserved latency codes never drive the bus
    cl_ok = (cl_code == CL_ONE) || (cl_code == CL_TWO) ||
            (cl_code == CL_THREE);
  end

  // Burst, bank and mode next state
  always_comb
  begin
    state_next    = state_reg;
    bank_next     = bank_reg;
    start_next    = start_reg;
    cnt_next      = cnt_reg;
    len_next      = len_reg;
    close_next    = close_reg;
    open_next     = open_reg;
    row_next      = row_reg;
    mode_next     = mode_reg;
    self_ref_next = o_self_refresh;
    acc_valid     = 1'b0;
    acc_write     = 1'b0;
    acc_bank      = bank_reg;
    acc_col       = start_reg;
    flush         = 1'b0;
    new_len       = burst_len(mode_reg[BL_LSB +: BL_W]);
    if (cmd_bus.cmd == CMD_WRITE && mode_reg[WBM_BIT])
      new_len = 9'h001;
    // Clock enable low freezes everything, like a stopped clock
    if (cmd_bus.active)
    begin
      // Leaving self refresh once the clock is enabled again
      if (o_self_refresh)
        self_ref_next = 1'b0;
      // Running burst carries on under deselect and no-op
      if (state_reg != ST_IDLE)
      begin
        acc_valid = 1'b1;
        acc_write = (state_reg == ST_WRITE);
        acc_col   = burst_col(start_reg, cnt_reg, len_reg,
                              mode_reg[BT_BIT]);
        cnt_next  = cnt_reg + 9'h001;
        // Page bursts wrap until stopped
        if (len_reg != LEN_PAGE && cnt_reg == len_reg - 9'h001)
        begin
          state_next = ST_IDLE;
          if (close_reg)
            open_next[bank_reg] = 1'b0;
        end
      end
      unique case (cmd_bus.cmd)
        CMD_READ, CMD_WRITE:
        begin
          // Access to an idle bank or in test mode is dropped
          if (normal_mode && open_reg[cmd_bus.bank])
          begin
            acc_valid  = 1'b1;
            acc_write  = (cmd_bus.cmd == CMD_WRITE);
            acc_bank   = cmd_bus.bank;
            acc_col    = burst_col(cmd_bus.addr[COL_W-1:0], 9'h000,
                                   new_len, mode_reg[BT_BIT]);
            bank_next  = cmd_bus.bank;
            start_next = cmd_bus.addr[COL_W-1:0];
            len_next   = new_len;
            cnt_next   = 9'h001;
            close_next = cmd_bus.addr[AUTO_CLOSE_BIT];
            if (new_len == 9'h001)
            begin
              state_next = ST_IDLE;
              if (cmd_bus.addr[AUTO_CLOSE_BIT])
                open_next[cmd_bus.bank] = 1'b0;
            end
            else if (cmd_bus.cmd == CMD_WRITE)
              state_next = ST_WRITE;
            else
              state_next = ST_READ;
          end
        end
        CMD_STOP:
        begin
          // Stop edge itself moves no word
          acc_valid  = 1'b0;
          state_next = ST_IDLE;
        end
        CMD_ACTIVE:
        begin
          open_next[cmd_bus.bank] = 1'b1;
          row_next[cmd_bus.bank]  = cmd_bus.addr[ROW_IDX_W-1:0];
        end
        CMD_CLOSE:
        begin
          if (cmd_bus.addr[AUTO_CLOSE_BIT])
          begin
            open_next  = '0;
            state_next = ST_IDLE;
          end
          else
          begin
            open_next[cmd_bus.bank] = 1'b0;
            if (cmd_bus.bank == bank_reg)
              state_next = ST_IDLE;
          end
        end
        CMD_LOAD:
        begin
          // Timing after load is the controller's duty
          mode_next = cmd_bus.addr;
          flush     = 1'b1;
        end
        CMD_SELF_REF:
          self_ref_next = 1'b1;
        CMD_AUTO_REF, CMD_NONE:
          ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state_reg      <= ST_IDLE;
      bank_reg       <= '0;
      start_reg      <= '0;
      cnt_reg        <= '0;
      len_reg        <= 9'h001;
      close_reg      <= 1'b0;
      open_reg       <= '0;
      mode_reg       <= MODE_RESET;
      o_self_refresh <= 1'b0;
      for (int b = 0; b < BANKS; b++)
        row_reg[b] <= '0;
    end
    else
    begin
      state_reg      <= state_next;
      bank_reg       <= bank_next;
      start_reg      <= start_next;
      cnt_reg        <= cnt_next;
      len_reg        <= len_next;
      close_reg      <= close_next;
      open_reg       <= open_next;
      mode_reg       <= mode_next;
      o_self_refresh <= self_ref_next;
      row_reg        <= row_next;
    end
  end

  // Array index of the open row in the accessed bank
  always_comb
  begin
    acc_idx = {acc_bank, row_reg[acc_bank], acc_col[COL_IDX_W-1:0]};
  end

  // Write path: mask acts in the same cycle as the data
  always_comb
  begin
    mem_next = mem_reg;
    if (acc_valid && acc_write)
    begin
      for (int l = 0; l < LANES; l++)
        if (!cmd_bus.mask[l])
          mem_next[acc_idx][l*8 +: 8] = i_dq_in[l*8 +: 8];
    end
  end

  // Array data carries no reset, only control state does
  always_ff @(posedge i_clk_sys)
  begin
    mem_reg <= mem_next;
  end

  sdram_read_pipe u_read_pipe (
    .i_clk_sys     (i_clk_sys),
    .i_rst         (i_rst),
    .i_advance     (cmd_bus.active),
    .i_flush       (flush),
    .i_latency     (cl_code[1:0]),
    .i_issue_valid (acc_valid && !acc_write && cl_ok),
    .i_issue_data  (mem_reg[acc_idx]),
    .i_mask        (cmd_bus.mask),
    .o_dq_out      (o_dq_out),
    .o_dq_oe       (o_dq_oe)
  );
endmodule

// ===== rtl/sdram_pkg.sv
// Purpose: Shared constants, types and helpers of the SDRAM device model
// Assumes: One system clock; controller logic on the same clock
// Notes:   Pin command codes are {row, column, write} strobes, active low
package sdram_pkg;
  // Widths
  localparam int ADDR_W = 12;
  localparam int DQ_W   = 32;
  localparam int LANES  = 4;
  localparam int BANK_W = 2;
  localparam int BANKS  = 4;
  localparam int COL_W  = 8;
  // Mode register fields
  localparam int BL_LSB         = 0;
  localparam int BL_W           = 3;
  localparam int BT_BIT         = 3;
  localparam int CL_LSB         = 4;
  localparam int CL_W           = 3;
  localparam int OPM_LSB        = 7;
  localparam int OPM_W          = 2;
  localparam int WBM_BIT        = 9;
  localparam int AUTO_CLOSE_BIT = 10;
  // Reset value: mode register is undefined at power-up, pick CL2, BL1
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;
  // Field encodings
  localparam logic [CL_W-1:0]  CL_ONE     = 3'h1;
  localparam logic [CL_W-1:0]  CL_TWO     = 3'h2;
  localparam logic [CL_W-1:0]  CL_THREE   = 3'h3;
  localparam logic [BL_W-1:0]  BL_ONE     = 3'h0;
  localparam logic [BL_W-1:0]  BL_TWO     = 3'h1;
  localparam logic [BL_W-1:0]  BL_FOUR    = 3'h2;
  localparam logic [BL_W-1:0]  BL_EIGHT   = 3'h3;
  localparam logic [BL_W-1:0]  BL_PAGE    = 3'h7;
  localparam logic [OPM_W-1:0] OPM_NORMAL = 2'h0;
  localparam logic [8:0]       LEN_PAGE   = 9'h100;
  // Strobe patterns {ras_n, cas_n, we_n}
  localparam logic [2:0] PIN_NOP     = 3'h7;
  localparam logic [2:0] PIN_ACTIVE  = 3'h3;
  localparam logic [2:0] PIN_READ    = 3'h5;
  localparam logic [2:0] PIN_WRITE   = 3'h4;
  localparam logic [2:0] PIN_STOP    = 3'h6;
  localparam logic [2:0] PIN_CLOSE   = 3'h2;
  localparam logic [2:0] PIN_REFRESH = 3'h1;
  localparam logic [2:0] PIN_LOAD    = 3'h0;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_ACTIVE = 4'h1, CMD_READ = 4'h2, CMD_WRITE = 4'h3,
    CMD_STOP = 4'h4, CMD_CLOSE = 4'h5, CMD_AUTO_REF = 4'h6,
    CMD_SELF_REF = 4'h7, CMD_LOAD = 4'h8
  } cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_READ = 3'h2, ST_WRITE = 3'h4
  } burst_type;

  // Burst length code to word count; reserved codes act as one word
  function automatic logic [8:0] burst_len(input logic [BL_W-1:0] code);
    case (code)
      BL_TWO:   return 9'h002;
      BL_FOUR:  return 9'h004;
      BL_EIGHT: return 9'h008;
      BL_PAGE:  return LEN_PAGE;
      default:  return 9'h001;
    endcase
  endfunction

  // Column of word cnt within the block selected by the start column
  function automatic logic [COL_W-1:0] burst_col(
    input logic [COL_W-1:0] start, input logic [8:0] cnt,
    input logic [8:0] len, input logic inter);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] k;
    m = COL_W'(len - 9'h001);
    k = cnt[COL_W-1:0];
    if (inter)
      return (start & ~m) | ((start ^ k) & m);
    return (start & ~m) | (COL_W'(start + k) & m);
  endfunction
endpackage

// ===== rtl/sdram_read_pipe.sv
// Purpose: Read latency delay line and byte-lane output drivers
// Assumes: Latency code already checked legal by the caller
// Notes:   Mask is delayed one stage so it lands two clocks later
`timescale 1ns/10ps
module sdram_read_pipe
  import sdram_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // Control
  input  wire logic             i_advance,
  input  wire logic             i_flush,
  input  wire logic [1:0]       i_latency,
  // Word fetched at this edge
  input  wire logic             i_issue_valid,
  input  wire logic [DQ_W-1:0]  i_issue_data,
  input  wire logic [LANES-1:0] i_mask,
  // Data pins
  output logic      [DQ_W-1:0]  o_dq_out,
  output logic      [LANES-1:0] o_dq_oe
);
  logic             st1_v_reg, st1_v_next, st2_v_reg, st2_v_next;
  logic [DQ_W-1:0]  st1_d_reg, st1_d_next, st2_d_reg, st2_d_next;
  logic [LANES-1:0] mask_d_reg, mask_d_next, oe_next;
  logic [DQ_W-1:0]  out_next;
  logic             sel_v;
  logic [DQ_W-1:0]  sel_d;

  // Output loads at edge n+m-1 for a read taken at edge n
  always_comb
  begin
    st1_v_next  = st1_v_reg;
    st1_d_next  = st1_d_reg;
    st2_v_next  = st2_v_reg;
    st2_d_next  = st2_d_reg;
    mask_d_next = mask_d_reg;
    out_next    = o_dq_out;
    oe_next     = o_dq_oe;
    sel_v       = st2_v_reg;
    sel_d       = st2_d_reg;
    if (i_latency == CL_ONE[1:0])
    begin
      sel_v = i_issue_valid;
      sel_d = i_issue_data;
    end
    else if (i_latency == CL_TWO[1:0])
    begin
      sel_v = st1_v_reg;
      sel_d = st1_d_reg;
    end
    if (i_advance)
    begin
      st1_v_next  = i_issue_valid;
      st1_d_next  = i_issue_data;
      st2_v_next  = st1_v_reg;
      st2_d_next  = st1_d_reg;
      mask_d_next = i_mask;
      out_next    = sel_d;
      oe_next     = {LANES{sel_v}} & ~mask_d_reg;
    end
    // After a mode load the bus must be released at once
    if (i_flush)
    begin
      st1_v_next = 1'b0;
      st2_v_next = 1'b0;
      oe_next    = '0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      st1_v_reg  <= 1'b0;
      st2_v_reg  <= 1'b0;
      st1_d_reg  <= '0;
      st2_d_reg  <= '0;
      mask_d_reg <= '1;
      o_dq_out   <= '0;
      o_dq_oe    <= '0;
    end
    else
    begin
      st1_v_reg  <= st1_v_next;
      st2_v_reg  <= st2_v_next;
      st1_d_reg  <= st1_d_next;
      st2_d_reg  <= st2_d_next;
      mask_d_reg <= mask_d_next;
      o_dq_out   <= out_next;
      o_dq_oe    <= oe_next;
    end
  end
endmodule
